// ### flow_i2c_map.vh
// constants for the flow sensor two-wire target
`ifndef FLOW_I2C_MAP_VH
`define FLOW_I2C_MAP_VH
`define TARGET_ADDR        7'h50
`define FLOW_ZERO_COUNTS   12'h199
`define FLOW_FULL_COUNTS   12'hE66
`define FIFO_DEPTH_WORDS   16
`define FLOW_WIDTH         12
`define BIT_COUNT_LAST     3'h7
`define BYTE_IDX_CHECKSUM  2'h0
`define BYTE_IDX_HIGH      2'h1
`define BYTE_IDX_LOW       2'h2
`endif

// ### sample_fifo.v
// synchronous fifo for flow samples
`timescale 1ns/1ns
module sample_fifo #(
   parameter WIDTH = 12,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             CORE_CLK,
   input  wire             RESET,
   input  wire [WIDTH-1:0] IN_DATA,
   input  wire             IN_VALID,
   output wire             IN_READY,
   output wire [WIDTH-1:0] OUT_DATA,
   output wire             OUT_VALID,
   input  wire             OUT_READY
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr_reg;
   reg [AW-1:0]    rd_ptr_reg;
   reg [AW:0]      count_reg;
   wire            push;
   wire            pop;

   assign IN_READY  = (count_reg != DEPTH[AW:0]);
   assign OUT_VALID = (count_reg != {(AW+1){1'b0}});
   assign push      = IN_VALID & IN_READY;
   assign pop       = OUT_VALID & OUT_READY;
   assign OUT_DATA  = mem[rd_ptr_reg];

   always @(posedge CORE_CLK) begin
      if (push) begin
         mem[wr_ptr_reg] <= IN_DATA;
      end
   end

   always @(posedge CORE_CLK) begin
      if (RESET) begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg  <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
         end
         if (push & ~pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop & ~push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule // sample_fifo

// ### flow_i2c_target.v
// two-wire target returning flow count and checksum
// Overview of operation
// - only the 7-bit address 0x50 is acknowledged, other addresses are ignored.
// - bus rates of 100 kHz and 400 kHz are handled by oversampling with the 10 MHz core clock.
// - a falling data edge while the clock line is high starts a transfer.
// - a rising data edge while the clock line is high ends the transfer and releases the bus.
// - each byte slot has 8 data bits and one response bit, low meaning acknowledge.
// - after a byte addressed to it the target pulls data low for the response slot then releases.
// - after an acknowledged byte another byte may follow or the controller may stop.
// - data is sampled on the rising clock edge and changes only while the clock is low.
// - both lines are driven only low or released, never driven high.
// - the count reads 409 at zero flow and 3686 at 35 liters per minute, linearly.
// - a read returns the checksum byte then the high and low flow bytes, msb first.
// - the flow value is 12 bits, only the low four bits of the high byte are valid.
// - the checksum is the negated modulo-256 sum of the data bytes.
`timescale 1ns/1ns
`include "flow_i2c_map.vh"
module flow_i2c_target #(
   parameter FLOW_W = `FLOW_WIDTH,
   parameter DEPTH  = `FIFO_DEPTH_WORDS
) (
   input  wire              CORE_CLK,
   input  wire              RESET,
   input  wire              SCL_IN,
   output wire              SCL_OUT,
   output wire              SCL_OE,
   input  wire              SDA_IN,
   output wire              SDA_OUT,
   output wire              SDA_OE,
   input  wire [FLOW_W-1:0] SAMPLE_DATA,
   input  wire              SAMPLE_VALID,
   output wire              SAMPLE_READY,
   output wire              BUSY
);
   localparam ST_IDLE = 3'h0;
   localparam ST_ADDR = 3'h1;
   localparam ST_AACK = 3'h2;
   localparam ST_TX   = 3'h3;
   localparam ST_RACK = 3'h4;
   localparam ST_RX   = 3'h5;
   localparam ST_WACK = 3'h6;
   localparam ST_ADEC = 3'h7;

   reg  [2:0]        scl_sync_reg;
   reg  [2:0]        sda_sync_reg;
   wire              scl_s;
   wire              sda_s;
   wire              scl_rise;
   wire              scl_fall;
   wire              start_det;
   wire              stop_det;
   reg  [2:0]        state_reg;
   reg  [2:0]        state_next;
   reg  [2:0]        bit_reg;
   reg  [2:0]        bit_next;
   reg  [7:0]        shift_reg;
   reg  [7:0]        shift_next;
   reg  [1:0]        byte_reg;
   reg  [1:0]        byte_next;
   reg               sda_low_reg;
   reg               sda_low_next;
   reg  [FLOW_W-1:0] flow_reg;
   reg  [FLOW_W-1:0] latch_reg;
   reg  [FLOW_W-1:0] latch_next;
   wire [FLOW_W-1:0] fifo_data;
   wire              fifo_valid;

   // modulo-256 negated sum of high and low data bytes
   function [7:0] csum;
      input [FLOW_W-1:0] v;
      begin
         csum = 8'h00 - ({4'h0, v[11:8]} + v[7:0]);
      end
   endfunction

   // one tx byte picked from the latched value
   function [7:0] tx_byte;
      input [1:0]        idx;
      input [FLOW_W-1:0] v;
      begin
         case (idx)
            `BYTE_IDX_CHECKSUM: tx_byte = csum(v);
            `BYTE_IDX_HIGH:     tx_byte = {4'h0, v[11:8]};
            default:            tx_byte = v[7:0];
         endcase
      end
   endfunction

   sample_fifo #(
      .WIDTH (FLOW_W),
      .DEPTH (DEPTH),
      .AW    (4)
   ) u_fifo (
      .CORE_CLK  (CORE_CLK),
      .RESET     (RESET),
      .IN_DATA   (SAMPLE_DATA),
      .IN_VALID  (SAMPLE_VALID),
      .IN_READY  (SAMPLE_READY),
      .OUT_DATA  (fifo_data),
      .OUT_VALID (fifo_valid),
      .OUT_READY (1'b1)
   );

   // keep newest sample; counts already span 409 to 3686
   always @(posedge CORE_CLK) begin
      if (RESET) begin
         flow_reg <= `FLOW_ZERO_COUNTS;
      end else if (fifo_valid) begin
         flow_reg <= fifo_data;
      end
   end

   // two-stage sync plus history bit for edges
   always @(posedge CORE_CLK) begin
      if (RESET) begin
         scl_sync_reg <= 3'h7;
         sda_sync_reg <= 3'h7;
      end else begin
         scl_sync_reg <= {scl_sync_reg[1:0], SCL_IN};
         sda_sync_reg <= {sda_sync_reg[1:0], SDA_IN};
      end
   end

   assign scl_s     = scl_sync_reg[1];
   assign sda_s     = sda_sync_reg[1];
   assign scl_rise  = scl_s & ~scl_sync_reg[2];
   assign scl_fall  = ~scl_s & scl_sync_reg[2];
   assign start_det = scl_s & scl_sync_reg[2] & ~sda_s & sda_sync_reg[2];
   assign stop_det  = scl_s & scl_sync_reg[2] & sda_s & ~sda_sync_reg[2];

   always @* begin
      state_next   = state_reg;
      bit_next     = bit_reg;
      shift_next   = shift_reg;
      byte_next    = byte_reg;
      sda_low_next = sda_low_reg;
      latch_next   = latch_reg;
      if (stop_det) begin
         state_next   = ST_IDLE;
         sda_low_next = 1'b0;
      end else if (start_det) begin
         state_next   = ST_ADDR;
         bit_next     = 3'h0;
         sda_low_next = 1'b0;
         latch_next   = flow_reg;
      end else begin
         case (state_reg)
            ST_ADDR: begin
               if (scl_rise) begin
                  shift_next = {shift_reg[6:0], sda_s};
                  bit_next   = bit_reg + 3'h1;
                  if (bit_reg == `BIT_COUNT_LAST) begin
                     state_next = ST_ADEC;
                  end
               end
            end
            ST_ADEC: begin
               if (scl_fall && shift_reg[7:1] == `TARGET_ADDR) begin
                  state_next   = ST_AACK;
                  sda_low_next = 1'b1;
               end else if (scl_fall) begin
                  state_next = ST_IDLE;
               end
            end
            ST_AACK: begin
               if (scl_fall) begin
                  bit_next = 3'h0;
                  if (shift_reg[0]) begin
                     state_next   = ST_TX;
                     byte_next    = `BYTE_IDX_CHECKSUM;
                     shift_next   = tx_byte(`BYTE_IDX_CHECKSUM, latch_reg);
                     sda_low_next = ~shift_next[7];
                  end else begin
                     state_next   = ST_RX;
                     sda_low_next = 1'b0;
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  bit_next = bit_reg + 3'h1;
                  if (bit_reg == `BIT_COUNT_LAST) begin
                     state_next   = ST_RACK;
                     sda_low_next = 1'b0;
                  end else begin
                     shift_next   = {shift_reg[6:0], 1'b0};
                     sda_low_next = ~shift_reg[6];
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  shift_next[0] = sda_s;
               end
               if (scl_fall) begin
                  if (shift_reg[0]) begin
                     state_next = ST_IDLE;
                  end else begin
                     state_next   = ST_TX;
                     byte_next    = (byte_reg == `BYTE_IDX_LOW) ? `BYTE_IDX_CHECKSUM : byte_reg + 2'h1;
                     shift_next   = tx_byte(byte_next, latch_reg);
                     sda_low_next = ~shift_next[7];
                  end
               end
            end
            ST_RX: begin
               if (scl_rise) begin
                  bit_next = bit_reg + 3'h1;
               end
               if (scl_fall && bit_reg == 3'h0) begin
                  state_next   = ST_WACK;
                  sda_low_next = 1'b1;
               end
            end
            ST_WACK: begin
               if (scl_fall) begin
                  state_next   = ST_RX;
                  sda_low_next = 1'b0;
               end
            end
            default: begin
               state_next   = ST_IDLE;
               sda_low_next = 1'b0;
            end
         endcase
      end
   end

   always @(posedge CORE_CLK) begin
      if (RESET) begin
         state_reg   <= ST_IDLE;
         bit_reg     <= 3'h0;
         shift_reg   <= 8'h00;
         byte_reg    <= 2'h0;
         sda_low_reg <= 1'b0;
         latch_reg   <= `FLOW_ZERO_COUNTS;
      end else begin
         state_reg   <= state_next;
         bit_reg     <= bit_next;
         shift_reg   <= shift_next;
         byte_reg    <= byte_next;
         sda_low_reg <= sda_low_next;
         latch_reg   <= latch_next;
      end
   end

   // open-drain: drive low or release only
   assign SDA_OUT = 1'b0;
   assign SDA_OE  = sda_low_reg;
   assign SCL_OUT = 1'b0;
   assign SCL_OE  = 1'b0;
   assign BUSY    = (state_reg != ST_IDLE);
endmodule // flow_i2c_target

// ### flow_i2c_props.sv
// assertions for the flow sensor two-wire target
`timescale 1ns/1ns
module flow_i2c_props #(
   parameter FLOW_W = 12,
   parameter DEPTH  = 16
) (
   input wire              CORE_CLK,
   input wire              RESET,
   input wire              SCL_IN,
   input wire              SCL_OUT,
   input wire              SCL_OE,
   input wire              SDA_IN,
   input wire              SDA_OUT,
   input wire              SDA_OE,
   input wire [FLOW_W-1:0] SAMPLE_DATA,
   input wire              SAMPLE_VALID,
   input wire              SAMPLE_READY,
   input wire              BUSY
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RESET);
   a_scl_never_pulled: assert property (!SCL_OE)
      else $error("scl pulled");
   a_sda_out_low: assert property (!SDA_OUT && !SCL_OUT)
      else $error("line driven high");
   a_reset_quiet: assert property ($fell(RESET) |-> !SDA_OE && !BUSY)
      else $error("not idle after reset");
   a_oe_scl_low: assert property ($changed(SDA_OE) |-> !SCL_IN && !$past(SCL_IN, 2))
      else $error("data changed with clock high");
   a_start_busy: assert property (SCL_IN && $past(SCL_IN) && $fell(SDA_IN) |-> ##[1:6] BUSY)
      else $error("start missed");
   a_stop_idle: assert property (SCL_IN && $past(SCL_IN) && $rose(SDA_IN) |-> ##[1:6] (!BUSY && !SDA_OE))
      else $error("stop missed");
   a_idle_release: assert property (!BUSY && $past(!BUSY) |-> !SDA_OE)
      else $error("idle but driving");
   a_oe_bounded: assert property ($rose(SDA_OE) |-> ##[1:1000] !SDA_OE)
      else $error("data held low");
   c_start: cover property (BUSY && $past(!BUSY));
   c_drive: cover property ($rose(SDA_OE));
   c_feed: cover property (SAMPLE_VALID && SAMPLE_READY);
endmodule // flow_i2c_props
bind flow_i2c_target flow_i2c_props #(.FLOW_W(FLOW_W), .DEPTH(DEPTH)) props (
   .CORE_CLK(CORE_CLK), .RESET(RESET), .SCL_IN(SCL_IN), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE),
   .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .SAMPLE_DATA(SAMPLE_DATA),
   .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_READY(SAMPLE_READY), .BUSY(BUSY));

// ### bus_ctrl_model.sv
// bus controller model driving the two-wire lines
`timescale 1ns/1ns
module bus_ctrl_model (
   input  wire CORE_CLK,
   input  wire SDA_OE,
   input  wire SCL_OE,
   output wire SCL,
   output wire SDA
);
   logic scl_low = 0;
   logic sda_low = 0;
   int   lo = 5;
   int   hi = 3;
   assign SCL = ~(scl_low | SCL_OE);
   assign SDA = ~(sda_low | SDA_OE);
   task automatic tick(input int n);
      repeat (n) @(negedge CORE_CLK);
   endtask
   task automatic start();
      sda_low = 0;
      tick(lo / 2);
      scl_low = 0;
      tick(hi);
      sda_low = 1;
      tick(hi);
      scl_low = 1;
   endtask
   task automatic stop();
      tick(lo / 2);
      sda_low = 1;
      tick(lo - lo / 2);
      scl_low = 0;
      tick(hi);
      sda_low = 0;
      tick(hi);
   endtask
   task automatic bit_x(input logic b, output logic r);
      tick(lo / 2);
      sda_low = ~b;
      tick(lo - lo / 2);
      scl_low = 0;
      tick(1);
      r = SDA;
      tick(hi - 1);
      scl_low = 1;
   endtask
   task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic r);
      logic t;
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], t);
         q[i] = t;
      end
      bit_x(a, r);
   endtask
endmodule // bus_ctrl_model

// ### flow_i2c_target_tb_top.sv
// testbench for the flow sensor two-wire target
`timescale 1ns/1ns
module flow_i2c_target_tb_top;
   logic        clk = 0;
   logic        rst = 1;
   logic [11:0] s_data = 0;
   logic        s_valid = 0;
   logic [7:0]  q;
   logic        r;
   wire         scl, sda, scl_out, scl_oe, sda_out, sda_oe, s_ready, busy;
   int          n_mismatch = 0;
   int          n_tests = 0;
   int          cyc = 0;
   always #50 clk = ~clk;
   bus_ctrl_model m (.CORE_CLK(clk), .SDA_OE(sda_oe), .SCL_OE(scl_oe), .SCL(scl), .SDA(sda));
   flow_i2c_target dut (.CORE_CLK(clk), .RESET(rst), .SCL_IN(scl), .SCL_OUT(scl_out),
      .SCL_OE(scl_oe), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .SAMPLE_DATA(s_data),
      .SAMPLE_VALID(s_valid), .SAMPLE_READY(s_ready), .BUSY(busy));
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         $display("unexpected at %0t: timeout", $time);
         close_out();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic push(input logic [11:0] v);
      @(negedge clk);
      s_data = v;
      s_valid = 1;
      chk({7'h0, s_ready}, 8'h01, "sample ready");
      @(negedge clk);
      s_valid = 0;
      repeat (6) @(negedge clk);
   endtask
   task automatic hdr(input logic [7:0] a, input logic want);
      m.start();
      m.xfer(a, 1, q, r);
      chk({7'h0, r}, {7'h0, want}, "address response");
   endtask
   task automatic t_read(input logic [11:0] v, input int lo, input int hi);
      logic [7:0] h;
      logic [7:0] l;
      h = {4'h0, v[11:8]};
      l = v[7:0];
      m.lo = lo;
      m.hi = hi;
      push(v);
      hdr(8'hA1, 0);
      m.xfer(8'hFF, 0, q, r);
      chk(q, 8'h00 - h - l, "checksum");
      push(~v);
      m.xfer(8'hFF, 0, q, r);
      chk(q, h, "high byte");
      m.xfer(8'hFF, 1, q, r);
      chk(q, l, "low byte");
      chk({7'h0, r}, 8'h01, "released in response slot");
      m.stop();
      repeat (8) @(negedge clk);
      chk({7'h0, busy}, 8'h00, "idle after stop");
      $display("read %h at %0d ns per bit done", v, (lo + hi) * 100);
   endtask
   task automatic t_wrong();
      logic [7:0] a;
      for (int i = 0; i < 2; i++) begin
         a = (i == 0) ? 8'hA3 : 8'h20;
         hdr(a, 1);
         m.xfer(8'hFF, 1, q, r);
         chk(q, 8'hFF, "foreign address read");
         m.stop();
      end
      $display("foreign addresses done");
   endtask
   task automatic t_nack();
      push(12'h5A3);
      hdr(8'hA1, 0);
      m.xfer(8'hFF, 1, q, r);
      chk(q, 8'h00 - 8'h05 - 8'hA3, "checksum before nack");
      m.xfer(8'hFF, 1, q, r);
      chk(q, 8'hFF, "silent after nack");
      m.stop();
      $display("nack done");
   endtask
   task automatic t_write();
      hdr(8'hA0, 0);
      m.xfer(8'h3C, 1, q, r);
      chk({7'h0, r}, 8'h00, "write data ack");
      m.stop();
      repeat (8) @(negedge clk);
      chk({7'h0, busy}, 8'h00, "idle after write");
      $display("write done");
   endtask
   initial begin
      repeat (16) @(negedge clk);
      rst = 0;
      repeat (4) @(negedge clk);
      t_read(12'h199, 5, 3);
      t_read(12'hE66, 5, 3);
      t_wrong();
      t_nack();
      t_write();
      t_read(12'h123, 50, 50);
      close_out();
   end
endmodule // flow_i2c_target_tb_top
